// ### hbcg_pkg.sv
// Constants and types for the H-bridge chopper gate control block
package hbcg_pkg;
  // ****************************************
  // Clock and oscillator timing
  // ****************************************
  localparam int CLK_PERIOD_NS    = 10;
  localparam int OSC_FREQ_KHZ     = 1600;
  localparam int CHOP_LAG_MAX_NS  = 1000;
  localparam int CHOP_LAG_CYCLES  = (CHOP_LAG_MAX_NS / CLK_PERIOD_NS < 1) ? 1 : CHOP_LAG_MAX_NS / CLK_PERIOD_NS;

  // ****************************************
  // Chopper divider
  // ****************************************
  localparam int        CHOP_DIV_W     = 4;
  localparam logic [3:0] CHOP_DIV_LAST = 4'hf;
  localparam logic [3:0] FAST_TICKS    = 4'h6;
  localparam logic [3:0] CHOP_HALF     = 4'h8;
  localparam logic [3:0] DIV_RESET     = 4'h0;

  // ****************************************
  // Overcurrent timing in oscillator periods
  // ****************************************
  localparam logic [3:0] OC_MASK_TICKS = 4'h4;
  localparam logic [3:0] OC_TRIP_TICK  = 4'h5;
  localparam logic [3:0] OC_MAX_TICKS  = 4'h8;

  // ****************************************
  // Gate patterns {hs1, hs2, ls1, ls2}
  // ****************************************
  localparam logic [3:0] GATES_OFF      = 4'h0;
  localparam logic [3:0] GATES_DIAG_A   = 4'h9;
  localparam logic [3:0] GATES_DIAG_B   = 4'h6;
  localparam logic [3:0] GATES_LOW_BOTH = 4'h3;

  typedef enum logic [1:0] {
    DECAY_SLOW,
    DECAY_FAST,
    DECAY_MIXED,
    DECAY_RSVD
  } hbcg_decay_e;

  typedef enum logic [1:0] {
    ST_OFF,
    ST_CHARGE,
    ST_SLOW,
    ST_FAST
  } hbcg_state_e;
endpackage

// ### hbcg_chop_if.sv
// Interface carrying chopper timing from the timer to the gate controller
`timescale 1ns/100ps
interface hbcg_chop_if;
  logic osc_tick;
  logic chop_start;
  logic fast_window;
  logic chop_clk;

  modport src (output osc_tick, output chop_start, output fast_window, output chop_clk);
  modport snk (input osc_tick, input chop_start, input fast_window, input chop_clk);
endinterface

// ### hbcg_chop_timer.sv
// Chopper timer: oscillator edge detect and divide-by-sixteen
`timescale 1ns/100ps
module hbcg_chop_timer (
  // Clock and reset
  input  wire logic  clk,
  input  wire logic  reset_n,
  input  wire logic  clk_en,
  // Oscillator and run control
  input  wire logic  osc_in,
  input  wire logic  run,
  // Timing out
  hbcg_chop_if.src   chop
);
  logic                                 osc_q_r;
  logic [hbcg_pkg::CHOP_DIV_W-1:0]      div_r;
  logic [hbcg_pkg::CHOP_DIV_W-1:0]      div_nxt;
  logic                                 chop_clk_r;
  logic                                 tick;
  logic                                 wrap;

  // ****************************************
  // Edge detect and divider
  // ****************************************
  // chop clock from rising slope
  assign tick    = osc_in & ~osc_q_r & run;
  assign wrap    = tick & (div_r == hbcg_pkg::CHOP_DIV_LAST);
  assign div_nxt = !run ? hbcg_pkg::DIV_RESET : (tick ? div_r + 4'h1 : div_r);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      osc_q_r    <= 1'b0;
      div_r      <= hbcg_pkg::DIV_RESET;
      chop_clk_r <= 1'b0;
    end else if (clk_en) begin
      osc_q_r    <= osc_in;
      div_r      <= div_nxt;
      chop_clk_r <= run & (div_nxt < hbcg_pkg::CHOP_HALF);
    end
  end

  assign chop.osc_tick    = tick;
  assign chop.chop_start  = wrap;
  assign chop.fast_window = div_r < hbcg_pkg::FAST_TICKS;
  assign chop.chop_clk    = chop_clk_r;
endmodule

// ### hbcg_top.sv
// Gate control for one H-bridge of a constant-current PWM stepper driver
`timescale 1ns/100ps
module hbcg_top (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  // Step controller
  input  wire logic        phase_dir,
  input  wire logic        bridge_enable,
  input  wire logic        standby,
  input  wire logic [1:0]  decay_sel,
  // Analog sense
  input  wire logic        chopper_rc_oscillator,
  input  wire logic        current_at_limit,
  input  wire logic        overcurrent_in,
  input  wire logic        thermal_in,
  // Gate drive
  output logic             high_side_first,
  output logic             high_side_second,
  output logic             low_side_first,
  output logic             low_side_second,
  // Status
  output logic             internal_chop_clock,
  output logic             overcurrent_shutdown,
  output logic             thermal_shutdown
);
  hbcg_chop_if             chop ();
  hbcg_pkg::hbcg_state_e   state_r;
  hbcg_pkg::hbcg_state_e   state_nxt;
  hbcg_pkg::hbcg_decay_e   decay_mode;
  hbcg_pkg::hbcg_state_e   decay_target;
  logic [3:0]              gates_r;
  logic [3:0]              oc_cnt_r;
  logic [3:0]              oc_cnt_nxt;
  logic                    oc_trip_r;
  logic                    th_trip_r;
  logic                    dir_r;
  logic                    stby_q_r;
  logic                    stby_rise;
  logic                    oc_fire;
  logic                    drive_ok;

  // ****************************************
  // Pattern lookup
  // ****************************************
  // legal pairs only
  function automatic logic [3:0] gate_pattern(hbcg_pkg::hbcg_state_e st, logic fwd);
    case (st)
      hbcg_pkg::ST_CHARGE: gate_pattern = fwd ? hbcg_pkg::GATES_DIAG_A : hbcg_pkg::GATES_DIAG_B;
      hbcg_pkg::ST_SLOW:   gate_pattern = hbcg_pkg::GATES_LOW_BOTH;
      hbcg_pkg::ST_FAST:   gate_pattern = fwd ? hbcg_pkg::GATES_DIAG_B : hbcg_pkg::GATES_DIAG_A;
      default:             gate_pattern = hbcg_pkg::GATES_OFF;
    endcase
  endfunction

  hbcg_chop_timer u_timer (
    .clk     (clk),
    .reset_n (reset_n),
    .clk_en  (clk_en),
    .osc_in  (chopper_rc_oscillator),
    .run     (standby),
    .chop    (chop.src)
  );

  // ****************************************
  // Protection
  // ****************************************
  assign stby_rise  = standby & ~stby_q_r;
  assign oc_cnt_nxt = !overcurrent_in ? 4'h0 :
                      ((chop.osc_tick && oc_cnt_r < hbcg_pkg::OC_TRIP_TICK) ? oc_cnt_r + 4'h1 : oc_cnt_r);
  // Fifth edge lands four to five periods after onset, inside the bound
  // trip on fifth tick
  assign oc_fire    = overcurrent_in & chop.osc_tick & (oc_cnt_r == hbcg_pkg::OC_TRIP_TICK - 4'h1);
  // Trips cut the gates on the very next edge, not one later
  // low enable stops the bridge; keeps it high in two-phase use
  assign drive_ok   = standby & bridge_enable & ~oc_trip_r & ~th_trip_r & ~oc_fire & ~thermal_in;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      oc_cnt_r  <= 4'h0;
      oc_trip_r <= 1'b0;
      th_trip_r <= 1'b0;
      stby_q_r  <= 1'b0;
    end else if (clk_en) begin
      oc_cnt_r  <= oc_cnt_nxt;
      stby_q_r  <= standby;
      // latch until standby rises, set wins
      oc_trip_r <= oc_fire | (oc_trip_r & ~stby_rise);
      // latch until standby rises, set wins
      th_trip_r <= thermal_in | (th_trip_r & ~stby_rise);
    end
  end

  // ****************************************
  // Chopper state machine
  // ****************************************
  assign decay_mode   = hbcg_pkg::hbcg_decay_e'(decay_sel);
  // mixed decay picks fast inside window
  assign decay_target = (decay_mode == hbcg_pkg::DECAY_FAST ||
                         (decay_mode == hbcg_pkg::DECAY_MIXED && chop.fast_window)) ?
                        hbcg_pkg::ST_FAST : hbcg_pkg::ST_SLOW;

  always_comb begin
    state_nxt = state_r;
    if (!drive_ok) begin
      state_nxt = hbcg_pkg::ST_OFF;
    end else begin
      case (state_r)
        hbcg_pkg::ST_OFF: begin
          state_nxt = hbcg_pkg::ST_CHARGE;
        end
        hbcg_pkg::ST_CHARGE: begin
          // Limit ignored on the start edge so a new period always charges
          if (current_at_limit && !chop.chop_start) begin
            state_nxt = decay_target;
          end
        end
        hbcg_pkg::ST_FAST: begin
          if (chop.chop_start) begin
            state_nxt = hbcg_pkg::ST_CHARGE;
          end else if (decay_mode == hbcg_pkg::DECAY_MIXED && !chop.fast_window) begin
            state_nxt = hbcg_pkg::ST_SLOW;
          end
        end
        hbcg_pkg::ST_SLOW: begin
          if (chop.chop_start) begin
            state_nxt = hbcg_pkg::ST_CHARGE;
          end
        end
        default: begin
          state_nxt = hbcg_pkg::ST_OFF;
        end
      endcase
    end
  end

  // Gates follow the next state so pattern and state never disagree
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_r <= hbcg_pkg::ST_OFF;
      gates_r <= hbcg_pkg::GATES_OFF;
      dir_r   <= 1'b1;
    end else if (clk_en) begin
      state_r <= state_nxt;
      dir_r   <= phase_dir;
      gates_r <= gate_pattern(state_nxt, phase_dir);
    end
  end

  assign high_side_first      = gates_r[3];
  assign high_side_second     = gates_r[2];
  assign low_side_first       = gates_r[1];
  assign low_side_second      = gates_r[0];
  assign internal_chop_clock  = chop.chop_clk;
  assign overcurrent_shutdown = oc_trip_r;
  assign thermal_shutdown     = th_trip_r;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n || !clk_en);

  AST_CHARGE_FWD: assert property (state_r == hbcg_pkg::ST_CHARGE && dir_r |-> gates_r == 4'h9)
    else $error("Charge forward pattern wrong");
  AST_SLOW: assert property (state_r == hbcg_pkg::ST_SLOW |-> gates_r == 4'h3)
    else $error("Slow decay pattern wrong");
  AST_FAST_FWD: assert property (state_r == hbcg_pkg::ST_FAST && dir_r |-> gates_r == 4'h6)
    else $error("Fast forward pattern wrong");
  AST_CHARGE_REV: assert property (state_r == hbcg_pkg::ST_CHARGE && !dir_r |-> gates_r == 4'h6)
    else $error("Charge reverse pattern wrong");
  AST_FAST_REV: assert property (state_r == hbcg_pkg::ST_FAST && !dir_r |-> gates_r == 4'h9)
    else $error("Fast reverse pattern wrong");
  AST_TWO_ON: assert property (state_r != hbcg_pkg::ST_OFF |-> $countones(gates_r) == 2 &&
                               gates_r != 4'hc && gates_r != 4'h5 && gates_r != 4'ha)
    else $error("Bridge does not have exactly two legal transistors on");
  AST_OC_MASK: assert property ($rose(oc_trip_r) |-> $past(oc_cnt_r) == 4'h4 && $past(overcurrent_in))
    else $error("Overcurrent trip before mask elapsed");
  AST_OC_TRIP: assert property (oc_fire |=> oc_trip_r && gates_r == 4'h0)
    else $error("Overcurrent did not turn bridge off");
  AST_OC_HOLD: assert property (oc_trip_r && !standby |=> oc_trip_r)
    else $error("Overcurrent latch released without standby rise");
  AST_TH_OFF: assert property (thermal_in |=> th_trip_r && gates_r == 4'h0)
    else $error("Thermal trip did not turn bridge off");
  AST_OFF_GATES: assert property (state_r == hbcg_pkg::ST_OFF |-> gates_r == 4'h0)
    else $error("Bridge off state still driving");
  AST_CHOP_LAG: assert property (chop.chop_start |=> chop.chop_clk)
    else $error("Chop clock late after period start");

  // Frozen clock enable must hold gates and state
  AST_FREEZE: assert property (@(posedge clk) disable iff (!reset_n) !clk_en |=> $stable(gates_r) && $stable(state_r))
    else $error("State moved while clock enable low");
  AST_ENABLE_OFF: assert property (!bridge_enable |=> gates_r == 4'h0)
    else $error("Disabled bridge still driving");
  AST_MIXED: assert property (state_r == hbcg_pkg::ST_FAST && decay_mode == hbcg_pkg::DECAY_MIXED &&
                              !chop.fast_window && !chop.chop_start && drive_ok
                              |=> state_r == hbcg_pkg::ST_SLOW)
    else $error("Mixed decay stayed fast past its window");

  CVR_CHARGE_TO_FAST: cover property (state_r == hbcg_pkg::ST_CHARGE ##1 state_r == hbcg_pkg::ST_FAST);
  CVR_MIXED_SLOW: cover property (state_r == hbcg_pkg::ST_FAST ##1 state_r == hbcg_pkg::ST_SLOW);
  CVR_OC_TRIP: cover property ($rose(oc_trip_r));
  CVR_RECOVER: cover property (oc_trip_r ##1 !oc_trip_r);
  CVR_THERMAL: cover property ($rose(th_trip_r));
endmodule

// ### hbcg_motor_model.sv
// Winding and oscillator model facing the gate controller
`timescale 1ns/100ps
module hbcg_motor_model #(
  parameter int OSC_HALF = 2,
  parameter int LIMIT    = 6
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // Bridge side
  input  wire logic       dir,
  input  wire logic [3:0] gates,
  // Sense back to the block
  output logic            osc,
  output logic            at_limit
);
  int unsigned ph  = 0;
  int unsigned cur = 0;
  wire logic   charging;

  initial osc = 1'b0;
  initial at_limit = 1'b0;

  // Oscillator free-runs, kept in step with clk
  always @(posedge clk) begin
    ph  <= (ph + 1) % (2 * OSC_HALF);
    osc <= ((ph + 1) % (2 * OSC_HALF)) < OSC_HALF;
  end

  // Current climbs only on the charge diagonal
  assign charging = (gates == (dir ? 4'h9 : 4'h6));
  always @(posedge clk) begin
    if (!reset_n)
      cur <= 0;
    else if (charging)
      cur <= cur + 1;
    else if (cur != 0)
      cur <= cur - 1;
    at_limit <= (cur >= LIMIT);
  end
endmodule

// ### hbridge_chopper_gate_control_tb.sv
// Self-checking bench for the H-bridge gate controller
`timescale 1ns/100ps
module hbridge_chopper_gate_control_tb;
  logic       clk, reset_n, clk_en, phase_dir, bridge_enable, standby, oc, th;
  logic [1:0] decay_sel;
  logic       hs1, hs2, ls1, ls2, chop, oc_flag, th_flag, osc, lim;
  wire  [3:0] g = {hs1, hs2, ls1, ls2};
  int         miscompares = 0;
  int         compares = 0;

  hbcg_top dut (.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .phase_dir(phase_dir),
    .bridge_enable(bridge_enable), .standby(standby), .decay_sel(decay_sel),
    .chopper_rc_oscillator(osc), .current_at_limit(lim), .overcurrent_in(oc), .thermal_in(th),
    .high_side_first(hs1), .high_side_second(hs2), .low_side_first(ls1), .low_side_second(ls2),
    .internal_chop_clock(chop), .overcurrent_shutdown(oc_flag), .thermal_shutdown(th_flag));
  hbcg_motor_model #(.OSC_HALF(2), .LIMIT(6)) winding (.clk(clk), .reset_n(reset_n), .dir(phase_dir),
    .gates(g), .osc(osc), .at_limit(lim));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ****************************************
  // Compare and timing helpers
  // ****************************************
  task automatic chk_v(string nm, logic [3:0] e, logic [3:0] s);
    compares++;
    if (e !== s) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic chk_r(string nm, int lo, int hi, int s);
    compares++;
    if (s < lo || s > hi) begin
      miscompares++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, s);
    end
  endtask
  task automatic tick(int n);
    repeat (n) begin
      @(posedge clk);
      #1;
      chk_v("gate pattern legal", 4'h1, {3'h0, g inside {4'h0, 4'h3, 4'h6, 4'h9}});
    end
  endtask
  task automatic restart();
    @(posedge clk) standby <= 1'b0;
    tick(10);
    @(posedge clk) standby <= 1'b1;
    tick(1);
  endtask
  task automatic to_limit(inout int c);
    while (lim !== 1'b1 && c < 200) begin tick(1); c++; end
    tick(1);
    c++;
  endtask
  task automatic to_chop_rise(output int n);
    n = 0;
    while (chop !== 1'b0 && n < 200) begin tick(1); n++; end
    while (chop !== 1'b1 && n < 200) begin tick(1); n++; end
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic s_patterns();
    int c;
    logic [1:0] sels [3] = '{hbcg_pkg::DECAY_SLOW, hbcg_pkg::DECAY_FAST, hbcg_pkg::DECAY_RSVD};
    for (int d = 0; d < 2; d++) begin
      foreach (sels[i]) begin
        @(posedge clk) phase_dir <= d[0];
        decay_sel <= sels[i];
        restart();
        chk_v("charge gates", d ? 4'h9 : 4'h6, g);
        c = 0;
        to_limit(c);
        chk_v("decay gates", (i == 1) ? (d ? 4'h6 : 4'h9) : 4'h3, g);
      end
    end
  endtask
  task automatic s_mixed();
    int c, p;
    @(posedge clk) phase_dir <= 1'b1;
    decay_sel <= hbcg_pkg::DECAY_MIXED;
    restart();
    to_chop_rise(c);
    to_chop_rise(p);
    chk_r("chop period", 64, 64, p);
    c = 0;
    to_limit(c);
    chk_v("mixed first decay", 4'h6, g);
    while (g !== 4'h3 && c < 100) begin tick(1); c++; end
    chk_r("fast window end", 23, 25, c);
  endtask
  task automatic s_enable();
    restart();
    @(posedge clk) bridge_enable <= 1'b0;
    tick(1);
    chk_v("disabled gates", 4'h0, g);
    @(posedge clk) bridge_enable <= 1'b1;
    tick(1);
    chk_v("enabled gates", 4'h9, g);
    // Frozen clock enable holds gates through a disable
    @(posedge clk) clk_en <= 1'b0;
    bridge_enable <= 1'b0;
    tick(4);
    chk_v("frozen gates", 4'h9, g);
    @(posedge clk) clk_en <= 1'b1;
    tick(1);
    chk_v("thawed gates", 4'h0, g);
    @(posedge clk) bridge_enable <= 1'b1;
  endtask
  task automatic s_overcurrent();
    int c;
    @(posedge clk) decay_sel <= hbcg_pkg::DECAY_SLOW;
    restart();
    // Spike of three periods stays masked
    @(posedge clk) oc <= 1'b1;
    tick(12);
    @(posedge clk) oc <= 1'b0;
    tick(20);
    chk_v("masked spike flag", 4'h0, {3'h0, oc_flag});
    @(posedge clk) oc <= 1'b1;
    c = 0;
    while (g !== 4'h0 && c < 60) begin tick(1); c++; end
    chk_r("trip latency", 16, 33, c);
    @(posedge clk) oc <= 1'b0;
    tick(30);
    chk_v("tripped gates", 4'h0, g);
    chk_v("trip flag", 4'h1, {3'h0, oc_flag});
    restart();
    chk_v("cleared flag", 4'h0, {3'h0, oc_flag});
    tick(1);
    chk_v("resumed gates", 4'h9, g);
  endtask
  task automatic s_thermal();
    @(posedge clk) th <= 1'b1;
    @(posedge clk) th <= 1'b0;
    tick(20);
    chk_v("thermal gates", 4'h0, g);
    chk_v("thermal flag", 4'h1, {3'h0, th_flag});
    restart();
    chk_v("thermal cleared", 4'h0, {3'h0, th_flag});
    tick(1);
    chk_v("thermal resumed", 4'h9, g);
  endtask

  task automatic give_verdict();
    if (miscompares == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    clk_en = 1'b1;
    phase_dir = 1'b1;
    bridge_enable = 1'b1;
    standby = 1'b0;
    decay_sel = 2'h0;
    oc = 1'b0;
    th = 1'b0;
    reset_n = 1'b0;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    tick(2);
    s_patterns();
    s_mixed();
    s_enable();
    s_overcurrent();
    s_thermal();
    give_verdict();
  end

  // Whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    give_verdict();
  end
endmodule
